// file: brc.sv
// read buffering control: apb registers, request fifo, policy engine
//
// Function
// R1 - a primary conventional read with full prefetch is capped at the primary byte count.
// R2 - the byte count code maps 000/011/111 to 512, 001 128, 010 256, 100 1024, 101 2048, 110 4096.
// R3 - a secondary conventional read with full prefetch is capped at the secondary byte count, reset 000.
// R4 - the primary relaxed bit lets later completions pass posted writes, reset clear.
// R5 - in PCI-X mode each transaction's own relaxed attribute decides ordering.
// R6 - a separate secondary relaxed bit does the same at the secondary side, reset clear.
// R7 - with special delayed read clear, a retried master that changes command is retried again.
// R8 - with it set, an MR/MRL/MRM change with equal address and enables is served; ignored in PCI-X.
// R9 - memory read prefetch: 00 one line, 01 reserved, 10 full, 11 stop after the first dword.
// R10 - the memory read prefetch field is ignored in PCI-X mode and resets to 00.
// R11 - read line prefetch: 00 one line, 10 full, 01 and 11 reserved, ignored in PCI-X.
// R12 - read multiple prefetch: 00 one line, 10 full, others reserved, reset 10, ignored in PCI-X.
// R13 - reserved bits 15, 3:0 and 31 read as zero.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "brc_defines.svh"

// ==========================================================
// request fifo
module brc_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // fill side
  input  wire logic [WIDTH-1:0]         in_data,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  // drain side
  output logic [WIDTH-1:0]              out_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  // fill level
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic        push;
  logic        pop;

  assign in_ready  = (s.cnt != DEPTH[AW:0]);
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign level     = s.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wp] = in_data;
      next_s.wp        = s.wp + 1'b1;
    end
    if (pop)
      next_s.rp = s.rp + 1'b1;
    if (push && !pop)
      next_s.cnt = s.cnt + 1'b1;
    else if (pop && !push)
      next_s.cnt = s.cnt - 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end
endmodule

// ==========================================================
// top
module brc
  import brc_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // read requests from the bus interfaces
  input  wire req_t        req_data,
  input  wire logic        req_valid,
  output logic             req_ready,
  // buffering decisions
  output dec_t             dec_data,
  output logic             dec_valid,
  input  wire logic        dec_ready
);

  typedef struct packed {
    st_t         st;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    dec_t        dec;
    logic [7:0]  n_dec;
    logic [7:0]  n_retry;
  } state_t;

  state_t      s;
  state_t      next_s;
  req_t        head;
  logic        head_valid;
  logic        pop;
  logic [4:0]  level;
  logic        setup;
  logic        access;
  logic        hit_ctrl;
  logic        hit_status;
  half_t       head_cfg;
  dec_t        head_dec;
  logic [31:0] wr_word;

  // ========================================================
  // byte count decode
  function automatic logic [12:0] mbc_bytes(input logic [2:0] code);
    case (code)
      3'h1:    mbc_bytes = `BRC_BC_128;  // [R2]
      3'h2:    mbc_bytes = `BRC_BC_256;
      3'h4:    mbc_bytes = `BRC_BC_1024;
      3'h5:    mbc_bytes = `BRC_BC_2048;
      3'h6:    mbc_bytes = `BRC_BC_4096;
      default: mbc_bytes = `BRC_BC_512;
    endcase
  endfunction

  // ========================================================
  // policy for one request under one control half
  function automatic dec_t decide(input req_t r, input half_t h);
    dec_t d;
    pf_t  code;
    d        = '0;
    d.origin = r.origin;
    case (r.cmd)
      CMD_MR:  code = h.mr;
      CMD_MRL: code = h.mrl;
      default: code = h.mrm;
    endcase
    if (r.pcix)
    begin
      // prefetch and delayed read fields do not apply
      d.fetch      = FETCH_SPLIT;  // [R10] [R11] [R12]
      d.byte_count = 13'h0000;
      d.bypass     = r.attr_ro;    // [R5]
      d.retry      = 1'b0;         // [R8]
    end
    else
    begin
      d.bypass = h.ro && r.not_first;                  // [R4] [R6]
      d.retry  = r.cmd_changed && !(h.sdr && r.match); // [R7] [R8]
      case (code)
        PF_FULL:
        begin
          d.fetch      = FETCH_FULL;
          d.byte_count = mbc_bytes(h.mbc);             // [R1] [R3]
        end
        PF_DWORD:
        begin
          // only the plain memory read defines code 11
          if (r.cmd == CMD_MR)
          begin
            d.fetch      = FETCH_DWORD;                // [R9]
            d.byte_count = `BRC_BC_DWORD;
          end
          else
          begin
            d.fetch      = FETCH_LINE;                 // [R11] [R12]
            d.byte_count = `BRC_BC_LINE;
          end
        end
        default:
        begin
          // reserved 01 is served as a single line
          d.fetch      = FETCH_LINE;                   // [R9] [R11]
          d.byte_count = `BRC_BC_LINE;
        end
      endcase
    end
    decide = d;
  endfunction

  // ========================================================
  // request fifo; back-pressure reaches req_ready
  brc_fifo
  #(
    .WIDTH ($bits(req_t)),
    .DEPTH (`BRC_FIFO_DEPTH)
  )
  u_fifo
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   (req_data),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .out_data  (head),
    .out_valid (head_valid),
    .out_ready (pop),
    .level     (level)
  );

  // ========================================================
  // combinational glue
  assign setup      = psel && !penable;
  assign access     = psel && penable;
  assign hit_ctrl   = (paddr == `BRC_CTRL_OFFSET);
  assign hit_status = (paddr == `BRC_STATUS_OFFSET);
  assign pready     = 1'b1;
  assign pslverr    = access && !hit_ctrl && !hit_status;
  assign prdata     = s.rdata;
  assign dec_data   = s.dec;
  assign dec_valid  = (s.st == ST_SEND);
  assign pop        = head_valid && ((s.st == ST_IDLE) || dec_ready);
  assign head_cfg   = head.origin ? half_t'(s.ctrl[31:16])
                                  : half_t'(s.ctrl[15:0]);
  assign head_dec   = decide(head, head_cfg);

  // byte lanes, then reserved bits forced to zero
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      wr_word[8*i +: 8] = pstrb[i] ? pwdata[8*i +: 8]
                                   : s.ctrl[8*i +: 8];
    wr_word = wr_word & {`BRC_HALF_WMASK, `BRC_HALF_WMASK}; // [R13]
  end

  // ========================================================
  // next state
  always_comb
  begin
    next_s = s;
    // read data is captured in the setup cycle
    if (setup && !pwrite)
    begin
      if (hit_ctrl)
        next_s.rdata = s.ctrl;
      else if (hit_status)
        next_s.rdata = {11'h000, level, s.n_retry, s.n_dec};
      else
        next_s.rdata = 32'h0000_0000;
    end
    if (access && pwrite && hit_ctrl)
      next_s.ctrl = wr_word;
    case (s.st)
      ST_IDLE:
      begin
        if (pop)
          next_s.st = ST_SEND;
      end
      ST_SEND:
      begin
        if (dec_ready && !pop)
          next_s.st = ST_IDLE;
      end
      default:
        next_s.st = ST_IDLE;
    endcase
    if (pop)
    begin
      next_s.dec   = head_dec;
      next_s.n_dec = s.n_dec + 8'h01;
      if (head_dec.retry)
        next_s.n_retry = s.n_retry + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s      <= '0;
      s.st   <= ST_IDLE;
      s.ctrl <= {`BRC_HALF_RESET, `BRC_HALF_RESET}; // [R3] [R10] [R12]
    end
    else
      s <= next_s;
  end

  // ========================================================
  // checks
  half_t p_cfg;
  half_t q_cfg;
  assign p_cfg = half_t'(s.ctrl[15:0]);
  assign q_cfg = half_t'(s.ctrl[31:16]);

  primary_cap_a: assert property ( // [R1] [R2]
    @(posedge pclk) disable iff (!presetn)
    pop && !head.origin && !head.pcix && head.cmd == CMD_MRM &&
    p_cfg.mrm == PF_FULL && p_cfg.mbc == 3'h6
    |=> dec_valid && dec_data.byte_count == 13'h1000)
    else $error("primary full prefetch not capped at 4096");

  second_cap_a: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    pop && head.origin && !head.pcix && head.cmd == CMD_MR &&
    q_cfg.mr == PF_FULL && q_cfg.mbc == 3'h1
    |=> dec_data.byte_count == 13'h0080 && dec_data.fetch == FETCH_FULL)
    else $error("secondary full prefetch not capped at 128");

  primary_order_a: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    pop && !head.origin && !head.pcix
    |=> dec_data.bypass == ($past(p_cfg.ro) && $past(head.not_first)))
    else $error("primary relaxed ordering wrong");

  pcix_order_a: assert property ( // [R5]
    @(posedge pclk) disable iff (!presetn)
    pop && head.pcix
    |=> dec_data.bypass == $past(head.attr_ro) &&
        dec_data.fetch == FETCH_SPLIT && !dec_data.retry)
    else $error("pcix ordering not from attribute");

  second_order_a: assert property ( // [R6]
    @(posedge pclk) disable iff (!presetn)
    pop && head.origin && !head.pcix && !q_cfg.ro
    |=> !dec_data.bypass)
    else $error("secondary bypass while disabled");

  retry_again_a: assert property ( // [R7]
    @(posedge pclk) disable iff (!presetn)
    pop && !head.pcix && head.cmd_changed && !head_cfg.sdr
    |=> dec_data.retry ##0 $changed(s.n_retry))
    else $error("changed command not retried");

  special_read_a: assert property ( // [R8]
    @(posedge pclk) disable iff (!presetn)
    pop && !head.pcix && head_cfg.sdr && head.match
    |=> !dec_data.retry)
    else $error("matching changed command retried");

  dword_stop_a: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    pop && !head.pcix && head.cmd == CMD_MR && head_cfg.mr == PF_DWORD
    |=> dec_data.fetch == FETCH_DWORD && dec_data.byte_count == 13'h0004)
    else $error("dword disconnect not applied");

  line_rsvd_a: assert property ( // [R11]
    @(posedge pclk) disable iff (!presetn)
    pop && !head.pcix && head.cmd == CMD_MRL && head_cfg.mrl != PF_FULL
    |=> dec_data.fetch == FETCH_LINE && dec_data.byte_count == 13'h0020)
    else $error("read line code not one line");

  reset_value_a: assert property ( // [R10] [R12]
    @(posedge pclk) $rose(presetn) |-> s.ctrl == 32'h0020_0020)
    else $error("control word reset value wrong");

  zero_rsvd_a: assert property ( // [R13]
    @(posedge pclk) disable iff (!presetn)
    access && !pwrite && hit_ctrl
    |-> (prdata & 32'h800f_800f) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  hold_dec_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    dec_valid && !dec_ready |=> dec_valid && $stable(dec_data))
    else $error("decision dropped under stall");

  full_seen_c: cover property (
    @(posedge pclk) disable iff (!presetn) !req_ready);
  retry_seen_c: cover property (
    @(posedge pclk) disable iff (!presetn) dec_valid && dec_data.retry);
  full_fetch_c: cover property (
    @(posedge pclk) disable iff (!presetn)
    dec_valid && dec_data.fetch == FETCH_FULL);
  bad_addr_c: cover property (
    @(posedge pclk) disable iff (!presetn) pslverr);

endmodule

`default_nettype wire

// file: brc_defines.svh
// constants for the read buffering control block
`ifndef BRC_DEFINES_SVH
`define BRC_DEFINES_SVH

// ==========================================================
// register map (byte addresses)
`define BRC_CTRL_OFFSET   12'h040
`define BRC_STATUS_OFFSET 12'h050

// ==========================================================
// layout of one 16-bit half; the secondary half sits at +16
`define BRC_SEC_LSB    16
`define BRC_HALF_WMASK 16'h7ff0
`define BRC_HALF_RESET 16'h0020
`define BRC_MBC_LSB    12
`define BRC_RO_BIT     11
`define BRC_SDR_BIT    10
`define BRC_MR_LSB     8
`define BRC_MRL_LSB    6
`define BRC_MRM_LSB    4

// ==========================================================
// request sizes in bytes, and the request fifo depth in entries
`define BRC_BC_128   13'h0080
`define BRC_BC_256   13'h0100
`define BRC_BC_512   13'h0200
`define BRC_BC_1024  13'h0400
`define BRC_BC_2048  13'h0800
`define BRC_BC_4096  13'h1000
`define BRC_BC_LINE  13'h0020
`define BRC_BC_DWORD 13'h0004
`define BRC_FIFO_DEPTH 16

`endif

// file: brc_master.sv
// bus master model: issues read requests and takes buffering decisions
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// request source and decision sink
module brc_master
  import brc_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // request side
  output req_t      req_data,
  output logic      req_valid,
  input  wire logic req_ready,
  // decision side
  input  wire dec_t dec_data,
  input  wire logic dec_valid,
  output logic      dec_ready
);
  logic stall = 1'b0;
  dec_t got[$];

  initial
  begin
    req_data  = '0;
    req_valid = 1'b0;
  end

  // a stalled sink keeps the engine's output register full
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      dec_ready <= 1'b0;
    else
    begin
      if (dec_valid && dec_ready)
        got.push_back(dec_data);
      dec_ready <= !stall;
    end

  task automatic send(req_t r);
    req_data  <= r;
    req_valid <= 1'b1;
    do @(posedge pclk); while (req_ready !== 1'b1);
  endtask

  // released data flips so that stale values are never trusted
  task automatic drop;
    req_valid <= 1'b0;
    req_data  <= ~req_data;
  endtask

  // holds a request until taken; cmd cycles MR, MRL, MRM
  task automatic burst(int n, output int took);
    took = 0;
    req_valid <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      req_data <= req_t'({1'b0, 2'(took % 3), 5'h0});
      @(posedge pclk);
      if (req_ready === 1'b1)
        took++;
    end
  endtask
endmodule

`default_nettype wire

// file: brc_pkg.sv
// types for the read buffering control block
package brc_pkg;

  typedef enum logic [1:0] {
    CMD_MR  = 2'h0,
    CMD_MRL = 2'h1,
    CMD_MRM = 2'h2
  } cmd_t;

  typedef enum logic [1:0] {
    PF_LINE  = 2'h0,
    PF_RSVD  = 2'h1,
    PF_FULL  = 2'h2,
    PF_DWORD = 2'h3
  } pf_t;

  typedef enum logic [1:0] {
    FETCH_LINE  = 2'h0,
    FETCH_FULL  = 2'h1,
    FETCH_DWORD = 2'h2,
    FETCH_SPLIT = 2'h3
  } fetch_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } st_t;

  // one control half as it sits in the register word
  typedef struct packed {
    logic       rsv_top;
    logic [2:0] mbc;
    logic       ro;
    logic       sdr;
    pf_t        mr;
    pf_t        mrl;
    pf_t        mrm;
    logic [3:0] rsv_low;
  } half_t;

  // read request seen at one interface
  typedef struct packed {
    logic origin;
    cmd_t cmd;
    logic pcix;
    logic attr_ro;
    logic cmd_changed;
    logic match;
    logic not_first;
  } req_t;

  // buffering decision for that request
  typedef struct packed {
    logic        origin;
    fetch_t      fetch;
    logic [12:0] byte_count;
    logic        retry;
    logic        bypass;
  } dec_t;

endpackage

// file: testbench.sv
// self-checking bench for the read buffering control block
`timescale 1ns/10ps
`default_nettype none
`include "brc_defines.svh"

// ==========================================================
// bench top
module testbench;
  import brc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  req_t        req_data;
  logic        req_valid, req_ready, dec_valid, dec_ready;
  dec_t        dec_data, d;
  int          err_total, num_checks;
  logic [12:0] full_bc [8] = '{`BRC_BC_512, `BRC_BC_128, `BRC_BC_256,
    `BRC_BC_512, `BRC_BC_1024, `BRC_BC_2048, `BRC_BC_4096, `BRC_BC_512};

  brc uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_data(req_data), .req_valid(req_valid), .req_ready(req_ready),
    .dec_data(dec_data), .dec_valid(dec_valid), .dec_ready(dec_ready));
  brc_master m (.pclk(pclk), .presetn(presetn), .req_data(req_data),
    .req_valid(req_valid), .req_ready(req_ready), .dec_data(dec_data),
    .dec_valid(dec_valid), .dec_ready(dec_ready));

  always #12.5 pclk = ~pclk;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; waits on pready, takes data at that edge
  task automatic apb(int w, logic [11:0] a, logic [31:0] wd);
    psel   <= 1'b1;
    pwrite <= w[0];
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // int fields so that plain numbers can be passed; each is cut to its width
  function automatic logic [15:0] hw(int bc, int ro, int sdr,
    int mr, int mrl, int mrm);
    return {1'b0, bc[2:0], ro[0], sdr[0], mr[1:0], mrl[1:0], mrm[1:0], 4'h0};
  endfunction

  // f = pcix, attr_ro, cmd_changed, match, not_first
  task automatic ask(logic o, logic [1:0] c, logic [4:0] f);
    int n;
    n = 0;
    m.send(req_t'({o, c, f}));
    m.drop();
    while (m.got.size() == 0 && n < 100)
    begin
      @(negedge pclk);
      n++;
    end
    chk("answered", 32'h1, {31'h0, m.got.size() > 0});
    d = (m.got.size() > 0) ? m.got.pop_front() : '0;
    @(posedge pclk);
  endtask

  task automatic t_regs;
    apb(0, `BRC_CTRL_OFFSET, '0);
    chk("ctrl reset", 32'h0020_0020, rd);
    apb(1, 12'h100, 32'hffff_ffff);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(0, 12'h100, '0);
    chk("unmapped read", 32'h0, rd);
    apb(1, `BRC_CTRL_OFFSET, 32'hffff_ffff);
    apb(0, `BRC_CTRL_OFFSET, '0);
    chk("reserved bits", 32'h7ff0_7ff0, rd);
    pstrb <= 4'h1;
    apb(1, `BRC_CTRL_OFFSET, 32'h0000_0000);
    pstrb <= 4'hf;
    apb(0, `BRC_CTRL_OFFSET, '0);
    chk("byte lane", 32'h7ff0_7f00, rd);
    $display("test regs done");
  endtask

  task automatic t_count;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 8; c++)
      begin
        // command walks so every read kind is used; each byte count code meets one read kind
        apb(1, `BRC_CTRL_OFFSET, {2{hw(c, 0, 0, 2, 2, 2)}});
        ask(s[0], 2'((c + 2) % 3), 5'h0);
        chk("full count", full_bc[c], d.byte_count);
        chk("full fetch", FETCH_FULL, d.fetch);
      end
    apb(1, `BRC_CTRL_OFFSET, {hw(6, 0, 0, 2, 0, 0), hw(1, 0, 0, 2, 0, 0)});
    ask(1'b1, 2'h0, 5'h0);
    chk("sec count", `BRC_BC_4096, d.byte_count);
    $display("test count done");
  endtask

  task automatic pf(logic [1:0] c, logic [15:0] h, int f,
    fetch_t ef, logic [12:0] eb);
    apb(1, `BRC_CTRL_OFFSET, {2{h}});
    ask(1'b0, c, f[4:0]);
    chk("fetch", ef, d.fetch);
    chk("count", eb, d.byte_count);
  endtask

  task automatic t_prefetch;
    pf(2'h0, hw(0, 0, 0, 2'h0, 0, 0), 0, FETCH_LINE, `BRC_BC_LINE);
    pf(2'h0, hw(0, 0, 0, 2'h3, 0, 0), 0, FETCH_DWORD, `BRC_BC_DWORD);
    pf(2'h0, hw(0, 0, 0, 2'h1, 0, 0), 0, FETCH_LINE, `BRC_BC_LINE);
    pf(2'h1, hw(0, 0, 0, 0, 2'h2, 0), 0, FETCH_FULL, `BRC_BC_512);
    pf(2'h1, hw(0, 0, 0, 2'h2, 2'h0, 0), 0, FETCH_LINE, `BRC_BC_LINE);
    pf(2'h2, hw(0, 0, 0, 0, 0, 2'h2), 0, FETCH_FULL, `BRC_BC_512);
    pf(2'h2, hw(0, 0, 0, 0, 0, 2'h0), 0, FETCH_LINE, `BRC_BC_LINE);
    pf(2'h0, hw(0, 0, 0, 2'h2, 0, 0), 5'h10, FETCH_SPLIT, 13'h0);
    $display("test prefetch done");
  endtask

  task automatic t_policy;
    apb(1, `BRC_CTRL_OFFSET, {hw(0, 1, 0, 0, 0, 0), hw(0, 0, 0, 0, 0, 0)});
    ask(1'b1, 2'h0, 5'h01);
    chk("sec bypass", 1, d.bypass);
    ask(1'b0, 2'h0, 5'h01);
    chk("prim strict", 0, d.bypass);
    ask(1'b0, 2'h0, 5'h19);
    chk("pcix attr", 1, d.bypass);
    apb(1, `BRC_CTRL_OFFSET, {2{hw(0, 1, 0, 0, 0, 0)}});
    ask(1'b0, 2'h0, 5'h01);
    chk("prim bypass", 1, d.bypass);
    ask(1'b0, 2'h0, 5'h00);
    chk("first strict", 0, d.bypass);
    ask(1'b0, 2'h0, 5'h11);
    chk("pcix no attr", 0, d.bypass);
    ask(1'b0, 2'h1, 5'h06);
    chk("retry kept", 1, d.retry);
    ask(1'b0, 2'h1, 5'h16);
    chk("pcix no retry", 0, d.retry);
    apb(1, `BRC_CTRL_OFFSET, {2{hw(0, 0, 1, 0, 0, 0)}});
    ask(1'b0, 2'h2, 5'h06);
    chk("changed served", 0, d.retry);
    ask(1'b0, 2'h1, 5'h04);
    chk("mismatch retry", 1, d.retry);
    $display("test policy done");
  endtask

  task automatic t_fifo;
    int took, n;
    fetch_t ef;
    apb(1, `BRC_CTRL_OFFSET, {2{hw(0, 0, 0, 2'h3, 2'h0, 2'h2)}});
    m.stall = 1'b1;
    m.burst(30, took);
    chk("full ready", 0, {31'h0, req_ready});
    // sixteen in the fifo plus one parked in the output register
    chk("held", 17, took);
    m.drop();
    // level 16, two retries and 36 decisions so far
    apb(0, `BRC_STATUS_OFFSET, '0);
    chk("status", 32'h0010_0224, rd);
    chk("status err", 0, {31'h0, er});
    m.stall = 1'b0;
    n = 0;
    while (m.got.size() < took && n < 200)
    begin
      @(negedge pclk);
      n++;
    end
    for (int i = 0; i < took; i++)
    begin
      d = (m.got.size() > 0) ? m.got.pop_front() : '1;
      ef = (i % 3 == 0) ? FETCH_DWORD
         : (i % 3 == 1) ? FETCH_LINE : FETCH_FULL;
      chk("order", ef, d.fetch);
    end
    @(posedge pclk);
    $display("test fifo done");
  endtask

  initial
  begin
    #500000;
    err_total++;
    give_verdict();
  end

  initial
  begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    err_total = 0;
    num_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_count();
    t_prefetch();
    t_policy();
    t_fifo();
    give_verdict();
  end
endmodule

`default_nettype wire
